// *** hw/watchdog_pkg.sv ***
/*
 holds the constants and carrier types of the watchdog flag block.
 assumes the instruction decoder delivers one-cycle instruction strobes.
*/
package watchdog_pkg;

	// --------------------------------------------------------------
	// timing
	// --------------------------------------------------------------
	localparam int unsigned CLK_HZ          = 20000000;
	localparam int unsigned STAGE_PERIOD_US = 1000;
	localparam int unsigned STAGE_CYCLES    =
		(STAGE_PERIOD_US * (CLK_HZ / 1000000));
	localparam int unsigned CNT_W           = 24;
	localparam int unsigned RESET_PULSE_US  = 1;
	localparam int unsigned RESET_CYCLES_I  =
		(RESET_PULSE_US * (CLK_HZ / 1000000));
	localparam logic [7:0]  RESET_CYCLES    = RESET_CYCLES_I[7:0];

	// --------------------------------------------------------------
	// flag and counter constants
	// --------------------------------------------------------------
	localparam logic FLAG_CLEAR = 1'h0;
	localparam logic FLAG_SET   = 1'h1;
	localparam logic [CNT_W-1:0] CNT_ZERO  = 24'h000000;
	localparam logic [CNT_W-1:0] CNT_ONE   = 24'h000001;
	localparam logic [7:0]       RST_ZERO  = 8'h00;
	localparam logic [7:0]       RST_ONE   = 8'h01;

	// --------------------------------------------------------------
	// power states
	// --------------------------------------------------------------
	typedef enum logic [1:0] {
		PWR_RUN     = 2'b00,
		PWR_ARMED   = 2'b01,
		PWR_BACKUP  = 2'b10
	} pwr_state_t;

	// instruction strobes from the decoder
	typedef struct packed {
		logic watchdog_service_instr;
		logic poweroff_enable_instr;
		logic poweroff_instr;
		logic other_instr;
	} instr_t;

	// flag view toward the core
	typedef struct packed {
		logic watchdog_arm_flag;
		logic watchdog_stage1_flag;
		logic watchdog_stage2_flag;
	} wdt_flags_t;

endpackage : watchdog_pkg

// *** hw/wdt_period_timer.sv ***
/*
 holds the free running period divider that clocks the watchdog stages.
 assumes a synchronous active low reset and a restart strobe.
*/
`timescale 1ns/100ps
`default_nettype none

module wdt_period_timer (
	// clock and reset
	input  wire logic clk,
	input  wire logic resetn,
	// control
	input  wire logic restart,
	// period tick
	output var  logic tick
);
	import watchdog_pkg::*;

	typedef struct packed {
		logic [CNT_W-1:0] count;
		logic             tick;
	} tmr_state_t;

	localparam logic [CNT_W-1:0] LAST = STAGE_CYCLES[CNT_W-1:0] - CNT_ONE;

	tmr_state_t s;
	tmr_state_t next_s;

	// ----------------------------------------------------------
	// period counting
	// ----------------------------------------------------------
	// restart realigns the window so a service gives a full period
	always_comb begin
		next_s      = s;
		next_s.tick = FLAG_CLEAR;
		if (restart) begin
			next_s.count = CNT_ZERO;
		end else if (s.count == LAST) begin
			next_s.count = CNT_ZERO;
			next_s.tick  = FLAG_SET;
		end else begin
			next_s.count = s.count + CNT_ONE;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tick = s.tick;

endmodule // wdt_period_timer

`default_nettype wire

// *** hw/watchdog_backup_flags.sv ***
/*
 holds the watchdog flag logic with the power-off sequencing into back-up.
 assumes instruction strobes are one cycle wide and synchronous to clk,
 and that a wake source outside leaves back-up by resetting the core.
*/
`timescale 1ns/100ps
`default_nettype none

// How it works
// - service instruction sets the arm flag outside back-up
// - service instruction clears first-stage flag
// - back-up entry initializes all watchdog flags
// - stage2 set during entry may still reset
// - power-off needs prior enable instruction
module watchdog_backup_flags (
	// clock and reset
	input  wire logic                      clk,
	input  wire logic                      resetn,
	// instruction strobes
	input  wire watchdog_pkg::instr_t      instr,
	// flags toward the core
	output var  watchdog_pkg::wdt_flags_t  flags,
	// power and reset outputs
	output var  logic                      osc_stop,
	output var  logic                      backup_mode,
	output var  logic                      wdt_reset
);
	import watchdog_pkg::*;

	typedef struct packed {
		pwr_state_t pwr;
		logic       arm;
		logic       stage1;
		logic       stage2;
		logic       rst;
		logic [7:0] rst_cnt;
		logic       osc_stop;
		logic       backup;
	} wd_state_t;

	wd_state_t s;
	wd_state_t next_s;
	logic      tick;
	logic      service;

	assign service = instr.watchdog_service_instr;

	// ----------------------------------------------------------
	// stage period source
	// ----------------------------------------------------------
	wdt_period_timer u_period (
		.clk    (clk),
		.resetn (resetn),
		.restart(service),
		.tick   (tick)
	);

	// ----------------------------------------------------------
	// flag and power sequencing
	// ----------------------------------------------------------
	// the timeout chain: tick sets stage1, a second tick with stage1
	// still set raises stage2, and stage2 while armed fires reset
	always_comb begin
		next_s = s;
		// reset pulse stretch so the device reset logic sees it
		if (s.rst_cnt != RST_ZERO) begin
			next_s.rst_cnt = s.rst_cnt - RST_ONE;
		end else begin
			next_s.rst = FLAG_CLEAR;
		end
		// watchdog stages run only while armed and not in back-up
		if (s.arm && !s.backup && tick) begin
			if (s.stage1) begin
				next_s.stage2 = FLAG_SET;
			end else begin
				next_s.stage1 = FLAG_SET;
			end
		end
		if (service) begin
			next_s.arm    = FLAG_SET;
			next_s.stage1 = FLAG_CLEAR;
		end
		// stage2 raised while armed: reset, even during entry
		if (s.arm && s.stage2) begin
			next_s.rst     = FLAG_SET;
			next_s.rst_cnt = RESET_CYCLES;
		end
		unique case (s.pwr)
			PWR_RUN: begin
				if (instr.poweroff_enable_instr) begin
					next_s.pwr = PWR_ARMED;
				end
			end
			PWR_ARMED: begin
				// a service or other instruction drops the enable; a repeated enable keeps it
				if (instr.poweroff_instr) begin
					next_s.pwr      = PWR_BACKUP;
					next_s.backup   = FLAG_SET;
					next_s.osc_stop = FLAG_SET;
					next_s.arm      = FLAG_CLEAR;
					next_s.stage1   = FLAG_CLEAR;
					next_s.stage2   = FLAG_CLEAR;
				end else if (instr.watchdog_service_instr ||
				             instr.other_instr) begin
					next_s.pwr = PWR_RUN;
				end
			end
			PWR_BACKUP: begin
				// held until device reset; flags stay initialized
				next_s.arm    = FLAG_CLEAR;
				next_s.stage1 = FLAG_CLEAR;
				next_s.stage2 = FLAG_CLEAR;
			end
			default: begin
				next_s.pwr = PWR_RUN;
			end
		endcase
		// race: stage2 rising in the entry cycle still resets; the
		// reset branch above reads the old, still clear stage2, so this branch raises it
		if (s.pwr == PWR_ARMED && instr.poweroff_instr &&
		    s.arm && s.stage1 && tick) begin
			next_s.rst     = FLAG_SET;
			next_s.rst_cnt = RESET_CYCLES;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// outputs straight from state flops
	assign flags.watchdog_arm_flag    = s.arm;
	assign flags.watchdog_stage1_flag = s.stage1;
	assign flags.watchdog_stage2_flag = s.stage2;
	assign osc_stop    = s.osc_stop;
	assign backup_mode = s.backup;
	assign wdt_reset   = s.rst;

endmodule // watchdog_backup_flags

`default_nettype wire

// *** bench/wdt_flags_checker.sv ***
/* checks of the watchdog flag block at its top ports.
 assumes one clock domain and the package compiled first. */
`timescale 1ns/100ps
`default_nettype none
module wdt_flags_checker (
	// clock and reset
	input wire logic                     clk,
	input wire logic                     resetn,
	// watched ports
	input wire watchdog_pkg::instr_t     instr,
	input wire watchdog_pkg::wdt_flags_t flags,
	input wire logic                     osc_stop,
	input wire logic                     backup_mode,
	input wire logic                     wdt_reset
);
	import watchdog_pkg::*;
	// -------------------------------
	// properties
	// -------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// service counts only when not entering or in back-up
	logic svc;
	assign svc = instr.watchdog_service_instr && !backup_mode
		&& !instr.poweroff_instr;
	// an enable stands through idle cycles until a service or other strobe comes
	logic pof_ok;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			pof_ok <= 1'b0;
		end else if (instr.watchdog_service_instr || instr.other_instr) begin
			pof_ok <= 1'b0;
		end else if (instr.poweroff_enable_instr) begin
			pof_ok <= 1'b1;
		end
	end
	a_service_arms: assert property (svc |=> flags.watchdog_arm_flag)
		else $error("arm flag not set");
	a_service_clears: assert property (svc |=> !flags.watchdog_stage1_flag)
		else $error("stage1 not cleared");
	a_backup_clears: assert property (backup_mode |-> flags == 3'h0)
		else $error("flags kept in back-up");
	a_backup_cause: assert property ($rose(backup_mode) |->
		$past(instr.poweroff_instr) && $past(pof_ok))
		else $error("back-up without sequence");
	a_backup_sticky: assert property (backup_mode |=> backup_mode && osc_stop)
		else $error("back-up left");
	a_lone_poweroff: assert property (instr.poweroff_instr
		&& $past(instr.other_instr) && !backup_mode |=> !backup_mode)
		else $error("power-off taken");
	a_timeout_reset: assert property ($rose(flags.watchdog_stage2_flag)
		|=> wdt_reset) else $error("no reset");
	a_reset_width: assert property ($rose(wdt_reset) |-> wdt_reset[*8])
		else $error("reset too short");
	cover property ($rose(backup_mode));
	cover property ($rose(flags.watchdog_stage1_flag));
	cover property ($rose(wdt_reset));
endmodule // wdt_flags_checker
bind watchdog_backup_flags wdt_flags_checker chk_i (.clk(clk),
	.resetn(resetn), .instr(instr), .flags(flags), .osc_stop(osc_stop),
	.backup_mode(backup_mode), .wdt_reset(wdt_reset));
`default_nettype wire

// *** bench/testbench.sv ***
/* self-checking bench of the watchdog flag block.
 assumes the package, the block and the checker compiled first. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import watchdog_pkg::*;
	logic       clk, resetn, osc_stop, backup_mode, wdt_reset;
	instr_t     instr;
	wdt_flags_t flags;
	int         num_errors, checked;
	watchdog_backup_flags uut (.clk(clk), .resetn(resetn), .instr(instr),
		.flags(flags), .osc_stop(osc_stop), .backup_mode(backup_mode),
		.wdt_reset(wdt_reset));
	// -------------------------------
	// helpers
	// -------------------------------
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task chk(input logic [2:0] got, input logic [2:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask
	task print_verdict;
		if (num_errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// two strobes back to back, then one idle edge
	task seq2(input instr_t a, input instr_t b);
		@(posedge clk) instr <= a;
		@(posedge clk) instr <= b;
		@(posedge clk) instr <= 4'h0;
		#1;
	endtask
	// bounded wait; the 1 ns lets the edge's updates land
	task wait_set(input int idx);
		for (int i = 0; i < 40100 && flags[idx] !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
	endtask
	// six low edges at the start, applied on a rising edge mid-run too
	task do_reset;
		@(posedge clk) resetn <= 1'b0;
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		#1;
		chk({osc_stop, backup_mode, wdt_reset}, 3'h0);
		chk(flags, 3'h0);
	endtask
	// -------------------------------
	// scenarios
	// -------------------------------
	task t_service;
		seq2(4'h8, 4'h0);
		chk(flags, 3'b100);
	endtask
	task t_refuse;
		seq2(4'h1, 4'h2);
		chk({1'b0, osc_stop, backup_mode}, 3'b000);
		// an instruction between enable and power-off drops the enable
		seq2(4'h4, 4'h1);
		seq2(4'h2, 4'h0);
		chk({1'b0, osc_stop, backup_mode}, 3'b000);
	endtask
	task t_timeout;
		wait_set(1);
		chk(flags, 3'b110);
		wait_set(0);
		chk({2'b00, flags[0]}, 3'b001);
		@(posedge clk);
		#1;
		chk({2'b00, wdt_reset}, 3'b001);
		// service clears stage1 only; stage2 waits for the core reset
		seq2(4'h8, 4'h0);
		chk(flags, 3'b101);
	endtask
	// serviced first, so entry sees an armed watchdog
	task t_backup;
		seq2(4'h8, 4'h0);
		seq2(4'h4, 4'h2);
		chk({1'b0, osc_stop, backup_mode}, 3'b011);
		chk(flags, 3'h0);
		seq2(4'h8, 4'h0);
		chk(flags, 3'h0);
	endtask
	// power-off taken in the cycle the second tick would raise stage2:
	// flags still initialize, yet the reset pulse fires
	task t_race;
		seq2(4'h8, 4'h0);
		wait_set(1);
		// lands enable one cycle before the tick, power-off with it
		repeat (STAGE_CYCLES - 3) @(posedge clk);
		seq2(4'h4, 4'h2);
		chk({osc_stop, backup_mode, wdt_reset}, 3'b111);
		chk(flags, 3'h0);
		repeat (RESET_CYCLES + 2) @(posedge clk);
		#1;
		chk({osc_stop, backup_mode, wdt_reset}, 3'b110);
	endtask
	initial begin
		resetn = 1'b0;
		instr = 4'h0;
		num_errors = 0;
		checked = 0;
		do_reset;
		t_service;
		t_refuse;
		t_timeout;
		do_reset;
		t_backup;
		do_reset;
		t_race;
		print_verdict;
	end
	// four stage periods plus margin
	initial begin
		repeat (90000) @(posedge clk);
		num_errors++;
		print_verdict;
	end
endmodule // testbench
`default_nettype wire
